// ==== logic/tlm_pkg.sv ====
// tlm_pkg: constants, codes and layout helpers shared by both ends of the ternary lookup
package tlm_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int ENT_W = 36;
	localparam int ACT_W = 70;
	localparam int ES_ENT_W = 35;
	localparam int ES_ACT_W = 285;
	localparam int MAX_WORDS = 16;
	localparam int ACT_WORDS = 4;
	localparam int KEY_W = MAX_WORDS * ENT_W;
	localparam int ADDR_W = 16;
	localparam int DIDX_W = 7;
	localparam int SLOT_W = 9;

	// ----------------------------------------------------------------
	// modelled depths (one block of words per lookup)
	// ----------------------------------------------------------------
	localparam int REGION = 16;
	localparam int SH_LUTS = 5;
	localparam int SH_DEPTH = SH_LUTS * REGION;
	localparam int SH_AW = 7;
	localparam int ES_DEPTH = 16;
	localparam int ES_AW = 4;
	localparam int ES_ADDRS_SMALL = 2048;
	localparam int ES_ADDRS_LARGE = 4096;

	// ----------------------------------------------------------------
	// default rule placement
	// ----------------------------------------------------------------
	localparam logic [15:0] CLS0_DFLT_BASE = 16'h8000;
	localparam logic [15:0] CLS1_DFLT_BASE = 16'h8720;
	localparam logic [15:0] CLS2_DFLT_BASE = 16'h8E40;
	localparam logic [15:0] ING_DFLT_BASE = 16'h9560;
	localparam logic [15:0] ES_DFLT_BASE = 16'h1000;
	localparam logic [6:0] CLS_DFLT_NUM = 7'h72;
	localparam logic [6:0] ING_DFLT_NUM = 7'h3A;
	localparam logic [6:0] ES_DFLT_NUM = 7'h35;
	localparam logic [8:0] SLOT_CLS1 = 9'h072;
	localparam logic [8:0] SLOT_CLS2 = 9'h0E4;
	localparam logic [8:0] SLOT_ING = 9'h156;
	localparam logic [8:0] SLOT_ES = 9'h190;
	localparam int DFLT_TOTAL = 453;
	localparam int DFLT_SHIFT = 4;

	// ----------------------------------------------------------------
	// lookup and size codes
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		LUT_FIRST_CLASSIFIER = 3'h0,
		LUT_SECOND_CLASSIFIER = 3'h1,
		LUT_THIRD_CLASSIFIER = 3'h2,
		LUT_INGRESS_SECOND_STAGE = 3'h3,
		LUT_PREFIX_MATCH = 3'h4,
		LUT_EGRESS_FIRST_STAGE = 3'h5
	} tlm_lut_t;

	typedef enum logic [2:0] {
		SZ_SINGLE_WIDTH = 3'h0,
		SZ_DOUBLE_WIDTH = 3'h1,
		SZ_QUAD_WIDTH = 3'h2,
		SZ_OCTAL_WIDTH = 3'h3,
		SZ_SIXTEEN_WIDTH = 3'h4
	} tlm_size_t;

	typedef struct packed {
		logic [2:0] w;
		logic [4:0] v;
	} tlm_tag_t;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [4:0] size_words(input logic [2:0] sz);
		return 5'h01 << sz;
	endfunction : size_words

	function automatic logic [15:0] dflt_base(input logic [2:0] lut);
		case (lut)
			3'h0: return CLS0_DFLT_BASE;
			3'h1: return CLS1_DFLT_BASE;
			3'h2: return CLS2_DFLT_BASE;
			3'h3: return ING_DFLT_BASE;
			3'h5: return ES_DFLT_BASE;
			default: return 16'h0000;
		endcase
	endfunction : dflt_base

	// prefix match has no default rules, so its count is zero
	function automatic logic [6:0] dflt_num(input logic [2:0] lut);
		case (lut)
			3'h0, 3'h1, 3'h2: return CLS_DFLT_NUM;
			3'h3: return ING_DFLT_NUM;
			3'h5: return ES_DFLT_NUM;
			default: return 7'h00;
		endcase
	endfunction : dflt_num

	function automatic logic [8:0] dflt_first(input logic [2:0] lut);
		case (lut)
			3'h1: return SLOT_CLS1;
			3'h2: return SLOT_CLS2;
			3'h3: return SLOT_ING;
			3'h5: return SLOT_ES;
			default: return 9'h000;
		endcase
	endfunction : dflt_first

	// egress defaults are packed one address apart, the others one block of 16
	function automatic logic [15:0] dflt_addr(input logic [2:0] lut, input logic [6:0] idx);
		if (lut == LUT_EGRESS_FIRST_STAGE)
			return dflt_base(lut) + {9'h000, idx};
		return dflt_base(lut) + {5'h00, idx, 4'h0};
	endfunction : dflt_addr

	function automatic logic [2:0] trail_zeros(input logic [3:0] off);
		if (off[0]) return 3'h0;
		if (off[1]) return 3'h1;
		if (off[2]) return 3'h2;
		return 3'h3;
	endfunction : trail_zeros

	// size tag that lives in the low bits of each entry word
	function automatic tlm_tag_t entry_tag(input logic [2:0] lut, input logic [2:0] sz,
			input logic [3:0] off);
		tlm_tag_t t;
		logic [2:0] tz;
		t = '0;
		tz = trail_zeros(off);
		case (lut)
			3'h0, 3'h1, 3'h2, 3'h4: begin
				if (off == 4'h0) begin
					t.w = sz + 3'h1;
					t.v = 5'h01 << sz;
				end else begin
					t.w = tz + 3'h1;
				end
			end
			3'h3: begin
				if (off == 4'h0) begin
					t.w = sz - 3'h1;
					t.v = 5'h01 << (sz - 3'h2);
				end else if (tz >= 3'h2) begin
					t.w = tz - 3'h1;
				end
			end
			default: t = '0;
		endcase
		return t;
	endfunction : entry_tag

endpackage : tlm_pkg

// ==== logic/tlm_if.sv ====
// tlm_if: write, key and result signals between key source and lookup memory
`timescale 1ns/1ps
interface tlm_if;
	// ----------------------------------------------------------------
	// rule write port
	// ----------------------------------------------------------------
	logic wr_valid;
	logic wr_egr;
	logic [15:0] wr_addr;
	logic [35:0] wr_entry;
	logic [35:0] wr_mask;
	logic [284:0] wr_action;
	// ----------------------------------------------------------------
	// key submission
	// ----------------------------------------------------------------
	logic key_valid;
	logic key_ready;
	logic [2:0] key_lut;
	logic [2:0] key_size;
	logic [6:0] key_dflt;
	logic [575:0] key_words;
	// ----------------------------------------------------------------
	// result
	// ----------------------------------------------------------------
	logic resp_valid;
	logic resp_hit;
	logic resp_dflt;
	logic resp_miss;
	logic resp_cnt;
	logic [15:0] resp_addr;
	logic [284:0] resp_action;

	modport dev (
		input wr_valid, wr_egr, wr_addr, wr_entry, wr_mask, wr_action,
		input key_valid, key_lut, key_size, key_dflt, key_words,
		output key_ready,
		output resp_valid, resp_hit, resp_dflt, resp_miss, resp_cnt, resp_addr, resp_action
	);

	modport host (
		output wr_valid, wr_egr, wr_addr, wr_entry, wr_mask, wr_action,
		output key_valid, key_lut, key_size, key_dflt, key_words,
		input key_ready,
		input resp_valid, resp_hit, resp_dflt, resp_miss, resp_cnt, resp_addr, resp_action
	);
endinterface : tlm_if

// ==== logic/tlm_lookup_dev.sv ====
// tlm_lookup_dev: ternary lookup memory with rule scan, default rules and hit counters
//
// Overview of operation
// [R1] first classifier: 114 defaults, 32768 plus 16n
// [R2] second classifier: 114 defaults, 34592 plus 16n
// [R3] third classifier: 114 defaults, 36416 plus 16n
// [R4] ingress stage entry start tags by size
// [R5] ingress offsets 4,12 one zero, 8 two
// [R6] ingress actions quad width, untagged
// [R7] ingress stage: 58 defaults, 38240 plus 16n
// [R8] ingress default hit on miss or no blocks
// [R9] ingress quad rule words continue bit order
// [R10] prefix match start tags by size
// [R11] prefix match non-first offset zero tags
// [R12] prefix match actions single width, untagged
// [R13] prefix match: no defaults, report miss
// [R14] one-bit saturating hit counter per rule
// [R15] egress has 2048/4096 addresses, unshared
// [R16] egress: 35-bit entry, 285-bit action
// [R17] egress words carry no size tag
// [R18] egress rule occupies offset zero only
// [R19] egress: 53 defaults at 4096 plus n
// [R20] tag in entry data, mask bits zero
// [R21] classifier default chosen with key, hit
// [R22] match needs every word; default otherwise
`timescale 1ns/1ps
module tlm_lookup_dev #(
	parameter int ES_ADDRS = tlm_pkg::ES_ADDRS_LARGE
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	// block allocation: one bit per shared lookup
	input wire logic [4:0] blk_assigned_i,
	// status
	output logic busy_o,
	// link to key source
	tlm_if.dev lk
);

	// ----------------------------------------------------------------
	// state and storage
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SCAN = 3'b010,
		ST_RESP = 3'b100
	} tlm_state_t;

	tlm_state_t state_r;
	logic [tlm_pkg::ENT_W-1:0] sh_ent_r [tlm_pkg::SH_DEPTH];
	logic [tlm_pkg::ENT_W-1:0] sh_msk_r [tlm_pkg::SH_DEPTH];
	logic [tlm_pkg::ACT_W-1:0] sh_act_r [tlm_pkg::SH_DEPTH];
	logic [tlm_pkg::SH_DEPTH-1:0] sh_vld_r;
	logic [tlm_pkg::SH_DEPTH-1:0] sh_cnt_r;
	logic [tlm_pkg::ES_ENT_W-1:0] es_ent_r [tlm_pkg::ES_DEPTH];
	logic [tlm_pkg::ES_ENT_W-1:0] es_msk_r [tlm_pkg::ES_DEPTH];
	logic [tlm_pkg::ES_ACT_W-1:0] es_act_r [tlm_pkg::ES_DEPTH];
	logic [tlm_pkg::ES_DEPTH-1:0] es_vld_r;
	logic [tlm_pkg::ES_DEPTH-1:0] es_cnt_r;
	logic [tlm_pkg::ES_ACT_W-1:0] dflt_act_r [tlm_pkg::DFLT_TOTAL];
	logic [tlm_pkg::DFLT_TOTAL-1:0] dflt_cnt_r;

	logic [2:0] lut_r;
	logic [2:0] size_r;
	logic [6:0] didx_r;
	logic [tlm_pkg::KEY_W-1:0] key_r;
	logic [4:0] ptr_r;
	logic key_ready_r;
	logic resp_valid_r, resp_hit_r, resp_dflt_r, resp_miss_r, resp_cnt_r;
	logic [15:0] resp_addr_r;
	logic [tlm_pkg::ES_ACT_W-1:0] resp_action_r;

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	// ternary compare: a zero mask bit is a cared bit, so tags must match exactly
	function automatic logic tern_eq(input logic [35:0] k, input logic [35:0] e,
			input logic [35:0] m);
		return ((k ^ e) & ~m) == 36'h0;
	endfunction : tern_eq

	// default rule slot written by an address, {valid, slot}
	function automatic logic [9:0] wr_dflt(input logic egr, input logic [15:0] a);
		logic [15:0] rel;
		logic [15:0] idx;
		logic [9:0] r;
		logic [2:0] lut;
		r = 10'h000;
		for (int l = 0; l < 6; l++) begin
			lut = 3'(l);
			rel = a - tlm_pkg::dflt_base(lut);
			idx = (lut == tlm_pkg::LUT_EGRESS_FIRST_STAGE) ? rel : (rel >> tlm_pkg::DFLT_SHIFT);
			if ((tlm_pkg::dflt_num(lut) != 7'h00) && (egr == (lut == tlm_pkg::LUT_EGRESS_FIRST_STAGE))
					&& (a >= tlm_pkg::dflt_base(lut)) && (idx < {9'h000, tlm_pkg::dflt_num(lut)})
					&& (tlm_pkg::dflt_addr(lut, idx[6:0]) == a))
				r = {1'b1, tlm_pkg::dflt_first(lut) + {2'h0, idx[6:0]}};
		end
		return r;
	endfunction : wr_dflt

	// ----------------------------------------------------------------
	// write decode
	// ----------------------------------------------------------------
	wire wr_sh = lk.wr_valid & ~lk.wr_egr & (lk.wr_addr < 16'(tlm_pkg::SH_DEPTH));
	// [R15] egress words sit apart from the shared blocks
	wire wr_es = lk.wr_valid & lk.wr_egr & (lk.wr_addr < 16'(tlm_pkg::ES_DEPTH))
		& (lk.wr_addr < 16'(ES_ADDRS));
	wire [9:0] wr_dsel = wr_dflt(lk.wr_egr, lk.wr_addr);
	wire wr_dv = lk.wr_valid & wr_dsel[9];
	wire [tlm_pkg::SH_AW-1:0] wr_si = lk.wr_addr[tlm_pkg::SH_AW-1:0];
	wire [tlm_pkg::ES_AW-1:0] wr_ei = lk.wr_addr[tlm_pkg::ES_AW-1:0];

	// ----------------------------------------------------------------
	// scan decode
	// ----------------------------------------------------------------
	wire is_es = (lut_r == tlm_pkg::LUT_EGRESS_FIRST_STAGE);
	wire lut_ok = (lut_r <= tlm_pkg::LUT_EGRESS_FIRST_STAGE);
	// [R16] egress entries and actions are single width only
	wire [4:0] n_words = is_es ? 5'h01 : tlm_pkg::size_words(size_r);
	wire [tlm_pkg::SH_AW-1:0] sh_base = {lut_r, 4'h0};
	// [R15] egress ignores block allocation
	wire assigned = is_es | (lut_ok & blk_assigned_i[lut_r]);
	wire [4:0] ptr_nxt = ptr_r + n_words;
	wire last_rule = ({1'b0, ptr_nxt} + {1'b0, n_words}) > 6'(tlm_pkg::REGION);
	wire [tlm_pkg::SH_AW-1:0] hit_si = sh_base + {2'h0, ptr_r};
	wire d_ok = lut_ok & (didx_r < tlm_pkg::dflt_num(lut_r));
	wire [8:0] d_slot = tlm_pkg::dflt_first(lut_r) + {2'h0, didx_r};
	wire [15:0] d_addr = tlm_pkg::dflt_addr(lut_r, didx_r);

	logic scan_hit;
	logic [tlm_pkg::ES_ACT_W-1:0] act_cat;
	logic [tlm_pkg::SH_AW-1:0] wi;

	// whole-rule compare of the candidate starting at ptr_r
	always_comb begin
		scan_hit = 1'b1;
		act_cat = '0;
		wi = '0;
		if (is_es) begin
			// [R18] egress rule: one word, entry and full action at offset zero
			scan_hit = es_vld_r[ptr_r[3:0]] & tern_eq({1'b0, key_r[tlm_pkg::ES_ENT_W-1:0]},
				{1'b0, es_ent_r[ptr_r[3:0]]}, {1'b1, es_msk_r[ptr_r[3:0]]});
			act_cat = es_act_r[ptr_r[3:0]];
		end else begin
			for (int w = 0; w < tlm_pkg::MAX_WORDS; w++) begin
				wi = hit_si + 7'(w);
				// [R22] every spanned word, tag bits included, must match
				if ((5'(w) < n_words) && !(sh_vld_r[wi]
						&& tern_eq(key_r[w*tlm_pkg::ENT_W +: tlm_pkg::ENT_W], sh_ent_r[wi], sh_msk_r[wi])))
					scan_hit = 1'b0;
				// [R9] action words concatenate low offset first
				if ((w < tlm_pkg::ACT_WORDS) && (5'(w) < n_words))
					act_cat[w*tlm_pkg::ACT_W +: tlm_pkg::ACT_W] = sh_act_r[wi];
			end
		end
	end

	// ----------------------------------------------------------------
	// rule storage writes
	// ----------------------------------------------------------------
	// entries keep no reset; only the valid bits and hit counters do, so unwritten words never match
	always_ff @(posedge core_clk_i) begin
		if (wr_sh) begin
			sh_ent_r[wr_si] <= lk.wr_entry;
			sh_msk_r[wr_si] <= lk.wr_mask;
			sh_act_r[wr_si] <= lk.wr_action[tlm_pkg::ACT_W-1:0];
		end
		if (wr_es) begin
			es_ent_r[wr_ei] <= lk.wr_entry[tlm_pkg::ES_ENT_W-1:0];
			es_msk_r[wr_ei] <= lk.wr_mask[tlm_pkg::ES_ENT_W-1:0];
			es_act_r[wr_ei] <= lk.wr_action;
		end
		if (wr_dv)
			dflt_act_r[wr_dsel[8:0]] <= lk.wr_action;
	end

	// valid bits and hit counters; a hit in the same cycle as a rewrite wins
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			sh_vld_r <= '0;
			es_vld_r <= '0;
			sh_cnt_r <= '0;
			es_cnt_r <= '0;
			dflt_cnt_r <= '0;
		end else begin
			if (wr_sh) sh_vld_r[wr_si] <= 1'b1;
			if (wr_sh) sh_cnt_r[wr_si] <= 1'b0;
			if (wr_es) es_vld_r[wr_ei] <= 1'b1;
			if (wr_es) es_cnt_r[wr_ei] <= 1'b0;
			if (wr_dv) dflt_cnt_r[wr_dsel[8:0]] <= 1'b0;
			// [R14] counters saturate at one
			if (state_r == ST_SCAN && assigned && scan_hit && !is_es) sh_cnt_r[hit_si] <= 1'b1;
			if (state_r == ST_SCAN && scan_hit && is_es) es_cnt_r[ptr_r[3:0]] <= 1'b1;
			if (state_r == ST_SCAN && (!assigned || (!scan_hit && last_rule)) && d_ok)
				dflt_cnt_r[d_slot] <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// key scan state machine
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			state_r <= ST_IDLE;
			key_ready_r <= 1'b0;
			busy_o <= 1'b0;
			resp_valid_r <= 1'b0;
			ptr_r <= '0;
		end else begin
			resp_valid_r <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					key_ready_r <= 1'b1;
					// [R21] default index is captured together with the key
					if (lk.key_valid && key_ready_r) begin
						state_r <= ST_SCAN;
						key_ready_r <= 1'b0;
						busy_o <= 1'b1;
						ptr_r <= '0;
					end
				end
				ST_SCAN: begin
					if (assigned && scan_hit) begin
						state_r <= ST_RESP;
						resp_valid_r <= 1'b1;
					end else if (!assigned || last_rule) begin
						state_r <= ST_RESP;
						resp_valid_r <= 1'b1;
					end else begin
						ptr_r <= ptr_nxt;
					end
				end
				ST_RESP: begin
					state_r <= ST_IDLE;
					busy_o <= 1'b0;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// key capture and result fields
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			lut_r <= '0;
			size_r <= '0;
			didx_r <= '0;
			key_r <= '0;
			resp_hit_r <= 1'b0;
			resp_dflt_r <= 1'b0;
			resp_miss_r <= 1'b0;
			resp_cnt_r <= 1'b0;
			resp_addr_r <= '0;
			resp_action_r <= '0;
		end else if (state_r == ST_IDLE && lk.key_valid && key_ready_r) begin
			lut_r <= lk.key_lut;
			size_r <= lk.key_size;
			didx_r <= lk.key_dflt;
			key_r <= lk.key_words;
		end else if (state_r == ST_SCAN && assigned && scan_hit) begin
			resp_hit_r <= 1'b1;
			resp_dflt_r <= 1'b0;
			resp_miss_r <= 1'b0;
			resp_cnt_r <= is_es ? es_cnt_r[ptr_r[3:0]] : sh_cnt_r[hit_si];
			resp_addr_r <= is_es ? {11'h000, ptr_r} : {9'h000, hit_si};
			resp_action_r <= act_cat;
		end else if (state_r == ST_SCAN && (!assigned || last_rule)) begin
			// [R1] [R2] [R3] [R7] [R19] default rule address and action
			// [R8] no match or no blocks falls back to the default
			// [R13] prefix match has none, so it reports a miss
			resp_hit_r <= 1'b0;
			resp_dflt_r <= d_ok;
			resp_miss_r <= ~d_ok;
			resp_cnt_r <= d_ok & dflt_cnt_r[d_slot];
			resp_addr_r <= d_ok ? d_addr : 16'h0000;
			resp_action_r <= d_ok ? dflt_act_r[d_slot] : '0;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign lk.key_ready = key_ready_r;
	assign lk.resp_valid = resp_valid_r;
	assign lk.resp_hit = resp_hit_r;
	assign lk.resp_dflt = resp_dflt_r;
	assign lk.resp_miss = resp_miss_r;
	assign lk.resp_cnt = resp_cnt_r;
	assign lk.resp_addr = resp_addr_r;
	assign lk.resp_action = resp_action_r;

endmodule : tlm_lookup_dev

// ==== logic/tlm_key_host.sv ====
// tlm_key_host: key source that tags rule words and keys and forwards lookups
`timescale 1ns/1ps
module tlm_key_host (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	// rule programming, one address word per request
	input wire logic prog_valid_i,
	input wire logic prog_raw_i,
	input wire logic [2:0] prog_lut_i,
	input wire logic [2:0] prog_size_i,
	input wire logic [3:0] prog_off_i,
	input wire logic [15:0] prog_addr_i,
	input wire logic [35:0] prog_data_i,
	input wire logic [35:0] prog_mask_i,
	input wire logic [284:0] prog_action_i,
	// lookup request
	input wire logic look_valid_i,
	input wire logic [2:0] look_lut_i,
	input wire logic [2:0] look_size_i,
	input wire logic [6:0] look_dflt_i,
	input wire logic [575:0] look_key_i,
	output logic look_ready_o,
	// lookup result
	output logic res_valid_o,
	output logic res_hit_o,
	output logic res_dflt_o,
	output logic res_miss_o,
	output logic res_cnt_o,
	output logic [15:0] res_addr_o,
	output logic [284:0] res_action_o,
	// link to lookup memory
	tlm_if.host lk
);

	// ----------------------------------------------------------------
	// tag insertion
	// ----------------------------------------------------------------
	wire prog_es = (prog_lut_i == tlm_pkg::LUT_EGRESS_FIRST_STAGE);
	// [R17] egress words and raw default writes carry no tag
	wire tlm_pkg::tlm_tag_t ptag = (prog_es | prog_raw_i) ? '0
		: tlm_pkg::entry_tag(prog_lut_i, prog_size_i, prog_off_i);
	// [R4] [R10] [R5] [R11] tag value sits in the low data bits
	wire [35:0] p_ent = (prog_data_i << ptag.w) | {31'h0, ptag.v};
	// [R20] mask is zero under the tag so it must match exactly
	wire [35:0] p_msk = prog_mask_i << ptag.w;
	wire look_es = (look_lut_i == tlm_pkg::LUT_EGRESS_FIRST_STAGE);
	wire [4:0] look_nw = look_es ? 5'h01 : tlm_pkg::size_words(look_size_i);

	logic [575:0] k_tagged;
	tlm_pkg::tlm_tag_t ktag;

	// key words get the same tags as the rule words they must hit
	always_comb begin
		k_tagged = '0;
		ktag = '0;
		for (int w = 0; w < tlm_pkg::MAX_WORDS; w++) begin
			ktag = look_es ? '0 : tlm_pkg::entry_tag(look_lut_i, look_size_i, 4'(w));
			if (5'(w) < look_nw)
				k_tagged[w*tlm_pkg::ENT_W +: tlm_pkg::ENT_W] =
					(look_key_i[w*tlm_pkg::ENT_W +: tlm_pkg::ENT_W] << ktag.w) | {31'h0, ktag.v};
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic wr_valid_r, wr_egr_r, key_valid_r, busy_r;
	logic [15:0] wr_addr_r;
	logic [35:0] wr_entry_r, wr_mask_r;
	logic [284:0] wr_action_r;
	logic [2:0] key_lut_r, key_size_r;
	logic [6:0] key_dflt_r;
	logic [575:0] key_words_r;

	// write word: one-cycle pulse, actions pass untouched
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			wr_valid_r <= 1'b0;
			wr_egr_r <= 1'b0;
			wr_addr_r <= '0;
			wr_entry_r <= '0;
			wr_mask_r <= '0;
			wr_action_r <= '0;
		end else begin
			wr_valid_r <= prog_valid_i;
			wr_egr_r <= prog_es;
			wr_addr_r <= prog_addr_i;
			wr_entry_r <= p_ent;
			wr_mask_r <= p_msk;
			// [R6] [R12] action words hold data only
			wr_action_r <= prog_action_i;
		end
	end

	// one lookup in flight; ready drops until the result returns
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			busy_r <= 1'b0;
			key_valid_r <= 1'b0;
			look_ready_o <= 1'b0;
			key_lut_r <= '0;
			key_size_r <= '0;
			key_dflt_r <= '0;
			key_words_r <= '0;
		end else begin
			look_ready_o <= ~busy_r & ~(look_valid_i & look_ready_o);
			if (look_valid_i && look_ready_o && !busy_r) begin
				busy_r <= 1'b1;
				key_valid_r <= 1'b1;
				key_lut_r <= look_lut_i;
				key_size_r <= look_es ? tlm_pkg::SZ_SINGLE_WIDTH : look_size_i;
				key_dflt_r <= look_dflt_i;
				key_words_r <= k_tagged;
			end else begin
				if (key_valid_r && lk.key_ready) key_valid_r <= 1'b0;
				if (lk.resp_valid) busy_r <= 1'b0;
			end
		end
	end

	// result copy
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			res_valid_o <= 1'b0;
			res_hit_o <= 1'b0;
			res_dflt_o <= 1'b0;
			res_miss_o <= 1'b0;
			res_cnt_o <= 1'b0;
			res_addr_o <= '0;
			res_action_o <= '0;
		end else begin
			res_valid_o <= lk.resp_valid;
			if (lk.resp_valid) begin
				res_hit_o <= lk.resp_hit;
				res_dflt_o <= lk.resp_dflt;
				res_miss_o <= lk.resp_miss;
				res_cnt_o <= lk.resp_cnt;
				res_addr_o <= lk.resp_addr;
				res_action_o <= lk.resp_action;
			end
		end
	end

	// ----------------------------------------------------------------
	// link drive
	// ----------------------------------------------------------------
	assign lk.wr_valid = wr_valid_r;
	assign lk.wr_egr = wr_egr_r;
	assign lk.wr_addr = wr_addr_r;
	assign lk.wr_entry = wr_entry_r;
	assign lk.wr_mask = wr_mask_r;
	assign lk.wr_action = wr_action_r;
	assign lk.key_valid = key_valid_r;
	assign lk.key_lut = key_lut_r;
	assign lk.key_size = key_size_r;
	assign lk.key_dflt = key_dflt_r;
	assign lk.key_words = key_words_r;

endmodule : tlm_key_host

// ==== tb/tlm_sva.sv ====
// tlm_sva: timing and result checks on the lookup link
`timescale 1ns/1ps
module tlm_sva (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	// key and result signals
	input wire logic key_valid,
	input wire logic key_ready,
	input wire logic [2:0] key_lut,
	input wire logic [6:0] key_dflt,
	input wire logic resp_valid,
	input wire logic resp_hit,
	input wire logic resp_dflt,
	input wire logic resp_miss,
	input wire logic [15:0] resp_addr
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	logic [2:0] lut_r;
	logic [6:0] n_r;
	// key fields kept until the result, since the key bus may move on
	always_ff @(posedge core_clk_i) begin
		if (key_valid && key_ready) begin
			lut_r <= key_lut;
			n_r <= key_dflt;
		end
	end
	// expected default address and default count of the latched lookup
	wire [15:0] exp_a = 16'h8000 + 16'h0720 * lut_r + {5'h00, n_r, 4'h0};
	wire [6:0] cnt_a = (lut_r == 3'h5) ? 7'h35 : (lut_r == 3'h3) ? 7'h3A : 7'h72;
	sequence s_take; key_valid && key_ready; endsequence
	sequence s_res; ##[1:17] resp_valid; endsequence
	property p_answer; s_take |-> s_res; endproperty
	a_answer: assert property (p_answer) else $error("no result in time");
	property p_busy; s_take |=> !key_ready; endproperty
	a_busy: assert property (p_busy) else $error("ready while busy");
	property p_dflt_addr; resp_valid && resp_dflt && lut_r != 3'h5 |-> resp_addr == exp_a; endproperty
	a_dflt_addr: assert property (p_dflt_addr) else $error("bad default addr");
	property p_es_dflt; resp_valid && resp_dflt && lut_r == 3'h5 |-> resp_addr == 16'h1000 + n_r; endproperty
	a_es_dflt: assert property (p_es_dflt) else $error("bad egress default");
	property p_no_pm_dflt; resp_valid && lut_r == 3'h4 |-> !resp_dflt; endproperty
	a_no_pm_dflt: assert property (p_no_pm_dflt) else $error("prefix default");
	property p_one_kind; resp_valid |-> $onehot({resp_hit, resp_dflt, resp_miss}); endproperty
	a_one_kind: assert property (p_one_kind) else $error("result kind");
	property p_miss_addr; resp_valid && resp_miss |-> resp_addr == 16'h0000; endproperty
	a_miss_addr: assert property (p_miss_addr) else $error("miss addr");
	property p_dflt_range; resp_valid && resp_dflt |-> n_r < cnt_a; endproperty
	a_dflt_range: assert property (p_dflt_range) else $error("default index");
endmodule : tlm_sva

// ==== tb/test_tcam_rule_layout_lookup.sv ====
// test_tcam_rule_layout_lookup: both ends joined, driven from the key source side
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
	$display("unexpected at %0t: got %h want %h", $time, a, b); end end
module test_tcam_rule_layout_lookup;
	logic clk, rst, pv, praw, lv, lrdy, rv, rhit, rdf, rmiss, rcnt, busy;
	logic [2:0] plut, psz, llut, lsz;
	logic [3:0] poff;
	logic [4:0] blk;
	logic [6:0] ldf;
	logic [15:0] paddr, raddr;
	logic [35:0] pdata, pmask;
	logic [284:0] pact, ract, act;
	logic [575:0] k;
	int mismatches, tests_run, cyc, i;
	int base[5] = '{32768, 34592, 36416, 38240, 4096};
	int step[5] = '{16, 16, 16, 16, 1};
	int cnt[5] = '{114, 114, 114, 58, 53};
	int lt[5] = '{0, 1, 2, 3, 5};
	tlm_if lk();
	tlm_lookup_dev #(.ES_ADDRS(4096)) tlm_lookup_dev_inst (.core_clk_i(clk), .sys_rst_i(rst),
		.blk_assigned_i(blk), .busy_o(busy), .lk(lk));
	tlm_key_host tlm_key_host_inst (.core_clk_i(clk), .sys_rst_i(rst), .prog_valid_i(pv),
		.prog_raw_i(praw), .prog_lut_i(plut), .prog_size_i(psz), .prog_off_i(poff),
		.prog_addr_i(paddr), .prog_data_i(pdata), .prog_mask_i(pmask), .prog_action_i(pact),
		.look_valid_i(lv), .look_lut_i(llut), .look_size_i(lsz), .look_dflt_i(ldf),
		.look_key_i(k), .look_ready_o(lrdy), .res_valid_o(rv), .res_hit_o(rhit),
		.res_dflt_o(rdf), .res_miss_o(rmiss), .res_cnt_o(rcnt), .res_addr_o(raddr),
		.res_action_o(ract), .lk(lk));
	tlm_sva tlm_sva_inst (.core_clk_i(clk), .sys_rst_i(rst), .key_valid(lk.key_valid),
		.key_ready(lk.key_ready), .key_lut(lk.key_lut), .key_dflt(lk.key_dflt),
		.resp_valid(lk.resp_valid), .resp_hit(lk.resp_hit), .resp_dflt(lk.resp_dflt),
		.resp_miss(lk.resp_miss), .resp_addr(lk.resp_addr));
	// free-running clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// one rule word per call, no handshake on the write side
	task prog(input [2:0] l, s, input [3:0] o, input [15:0] a, input [35:0] d, m,
			input [284:0] ac, input r);
		@(negedge clk);
		{pv, plut, psz, poff, paddr, pdata, pmask, pact, praw} = {1'b1, l, s, o, a, d, m, ac, r};
		@(negedge clk);
		pv = 1'b0;
	endtask : prog
	// one lookup, waits for ready then for the result pulse
	task look(input [2:0] l, s, input [6:0] n, input [2:0] kind, input [15:0] a);
		int j;
		for (j = 0; j < 40 && lrdy !== 1'b1; j++) @(negedge clk);
		{lv, llut, lsz, ldf} = {1'b1, l, s, n};
		@(negedge clk);
		lv = 1'b0;
		@(negedge clk);
		`CHK(busy, 1'b1)
		for (j = 0; j < 40 && rv !== 1'b1; j++) @(negedge clk);
		`CHK({rv, rhit, rdf, rmiss, raddr}, {1'b1, kind, a})
	endtask : look
	task give_verdict;
		$display("counts: %0d compares, %0d mismatches", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : give_verdict
	// hang guard, far beyond the sequence length
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			give_verdict();
		end
	end
	// test sequence
	initial begin
		{rst, pv, praw, lv, plut, psz, poff, paddr, pdata, pmask, pact, llut, lsz, ldf, k, blk} = '0;
		rst = 1'b1;
		repeat (13) @(negedge clk);
		rst = 1'b0;
		for (i = 0; i < 5; i++) begin
			look(3'(lt[i]), 0, 7'(cnt[i] - 1), 3'b010, 16'(base[i] + step[i] * (cnt[i] - 1)));
			look(3'(lt[i]), 0, 7'(cnt[i]), 3'b001, 16'h0000);
		end
		look(4, 0, 0, 3'b001, 16'h0000);
		$display("default rules done");
		blk = 5'h1F;
		prog(4, 0, 0, 16'h0040, 36'h0, 36'hFFFFFFFFF, 285'h2A5, 0);
		for (i = 0; i < 3; i++) begin
			look(4, 0, 0, 3'b100, 16'h0040);
			`CHK({rcnt, ract}, {i != 0, 285'h2A5})
		end
		prog(5, 0, 0, 16'h0003, 36'h012345678, 36'h0, {5'h1F, 275'h0, 5'h05}, 1);
		k = {540'h0, 36'h012345678};
		look(5, 0, 7, 3'b100, 16'h0003);
		`CHK(ract, {5'h1F, 275'h0, 5'h05})
		k[0] = 1'b1;
		look(5, 0, 7, 3'b010, 16'h1007);
		$display("prefix and egress done");
		act = '0;
		for (i = 0; i < 4; i++) begin
			prog(3, 2, 4'(i), 16'(48 + i), 36'(i + 5), 36'h0, 285'(i + 1), 0);
			k[i * 36 +: 36] = 36'(i + 5);
			act[i * 70 +: 70] = 70'(i + 1);
		end
		look(3, 2, 9, 3'b100, 16'h0030);
		`CHK(ract, act)
		k[72] = 1'b0;
		look(3, 2, 9, 3'b010, 16'(38240 + 16 * 9));
		$display("ingress quad rule done");
		give_verdict();
	end
endmodule : test_tcam_rule_layout_lookup
